//--- bench/tb.sv
// Self-checking bench for the endpoint descriptor bank with a shadow descriptor model
`timescale 1ns/1ps
`default_nettype none
`include "ueb_params.svh"
module tb
  import ueb_pkg::*;
;
  logic clk, srst, bus_wr, bus_rd, lk_ready, lk_allow, lk_toggle, lk_use_y, txn_irq;
  logic [6:0]  bus_addr, lk_size, lk_count;
  logic [7:0]  bus_wdata, bus_rdata;
  logic [10:0] lk_start_addr;
  ueb_resp_t   lk_resp;
  logic        lk_valid, lk_dir_in, done_valid, done_dir_in, stall_set;
  logic [2:0]  lk_ep, done_ep, stall_ep;
  logic [6:0]  done_count;
  logic [7:0]  sh [2][8][8];
  logic [7:0]  rd_q[$];
  logic [30:0] lk_q[$];
  logic        irq_q[$];
  logic        rd_d, lk_d, dn_d;
  int          error_cnt, num_checks, cyc;

  ueb_desc_bank dut (.clk, .srst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .lk_valid, .lk_dir_in, .lk_ep, .lk_ready, .lk_allow, .lk_start_addr, .lk_size,
    .lk_count, .lk_toggle, .lk_use_y, .lk_resp, .done_valid, .done_dir_in, .done_ep,
    .done_count, .stall_set, .stall_ep, .txn_irq);
  ueb_host_model h (.clk, .lk_valid, .lk_dir_in, .lk_ep, .done_valid, .done_dir_in,
    .done_ep, .done_count, .stall_set, .stall_ep);

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic miss(input string s);
    error_cnt++;
    $display("MISMATCH at %0t: %s", $time, s);
  endtask
  task automatic cmp_rd(input logic [7:0] e);
    num_checks++;
    if (bus_rdata !== e) miss($sformatf("read %h want %h", bus_rdata, e));
  endtask
  task automatic cmp_lk(input logic [30:0] e);
    num_checks++;
    if ({lk_ready, lk_allow, lk_start_addr, lk_size, lk_count, lk_toggle, lk_use_y, lk_resp}
        !== e) miss($sformatf("lookup want %h", e));
  endtask
  task automatic cmp_irq(input logic e);
    num_checks++;
    if (txn_irq !== e) miss("completion event");
  endtask

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Register bus: one-cycle strobes, shadow follows the write masks
  task automatic wr(input logic d, input logic [2:0] e, input logic [2:0] o, input logic [7:0] v);
    @(posedge clk);
    {bus_addr, bus_wdata, bus_wr} <= {d, e, o, v, 1'b1};
    @(posedge clk);
    bus_wr <= 1'b0;
    if (e != 3'h0 && o != `UEB_OFF_SPARE0 && o != `UEB_OFF_SPARE1)
      sh[d][e][o] = v & (o == `UEB_OFF_CFG ? `UEB_CFG_WMASK :
                         o == `UEB_OFF_SIZE ? `UEB_SIZE_WMASK : `UEB_FULL_WMASK);
  endtask
  task automatic rd(input logic d, input logic [2:0] e, input logic [2:0] o);
    rd_q.push_back(sh[d][e][o]);
    @(posedge clk);
    {bus_addr, bus_rd} <= {d, e, o, 1'b1};
    @(posedge clk);
    bus_rd <= 1'b0;
  endtask

  // Lookup note: stall beats NAK; Y only when double-buffered and toggle set
  task automatic lk(input logic d, input logic [2:0] e);
    logic [7:0] c, n;
    logic       y;
    logic [1:0] r;
    c = sh[d][e][`UEB_OFF_CFG];
    y = c[`UEB_CFG_DBL_BUF] & c[`UEB_CFG_TOGGLE];
    n = sh[d][e][y ? `UEB_OFF_YCNT : `UEB_OFF_XCNT];
    r = c[`UEB_CFG_STALL] ? UEB_RESP_STALL : (!c[7] || n[7]) ? UEB_RESP_NAK : UEB_RESP_ACK;
    lk_q.push_back({1'b1, c[7], sh[d][e][y ? `UEB_OFF_YBASE : `UEB_OFF_XBASE], 3'h0,
                    sh[d][e][`UEB_OFF_SIZE][6:0], n[6:0], c[5], y, r});
    h.lookup(d, e);
  endtask

  // Completion note: ignored unless allowed; flips toggle and marks the used buffer
  task automatic cp(input logic d, input logic [2:0] e, input logic [6:0] n);
    logic [7:0] c;
    logic [2:0] o;
    c = sh[d][e][`UEB_OFF_CFG];
    o = (c[`UEB_CFG_DBL_BUF] & c[`UEB_CFG_TOGGLE]) ? `UEB_OFF_YCNT : `UEB_OFF_XCNT;
    irq_q.push_back(e != 3'h0 && c[7] && c[`UEB_CFG_IRQ_EN]);
    h.complete(d, e, n);
    if (e != 3'h0 && c[7]) begin
      sh[d][e][o] = {1'b1, d ? sh[d][e][o][6:0] : n};
      sh[d][e][`UEB_OFF_CFG][`UEB_CFG_TOGGLE] = ~c[`UEB_CFG_TOGGLE];
    end
  endtask
  task automatic st(input logic [2:0] e);
    h.stall(e);
    if (e != 3'h0) sh[1][e][`UEB_OFF_CFG][`UEB_CFG_STALL] = 1'b1;
  endtask

  // Legal random byte per entry: iso kept clear, counts and size at most 64
  function automatic logic [7:0] rnd(input logic [2:0] o);
    logic [7:0] v;
    v = 8'($urandom);
    if (o == `UEB_OFF_CFG) v[`UEB_CFG_ISO] = 1'b0;
    if (o == `UEB_OFF_XCNT || o == `UEB_OFF_YCNT || o == `UEB_OFF_SIZE)
      v[6:0] = 7'($urandom_range(0, 64));
    return v;
  endfunction

  // Result watcher: each result takes the oldest note of its kind
  // Quiet while reset is up or unknown, so the time-zero clock edge cannot raise a false stray
  always @(negedge clk) begin
    if (srst !== 1'b0) begin
      {rd_d, lk_d, dn_d} = 3'b000;
    end else begin
      if (rd_d) begin
        if (rd_q.size() == 0) miss("read without note");
        else cmp_rd(rd_q.pop_front());
      end
      if (lk_d) begin
        if (lk_q.size() == 0) miss("lookup without note");
        else cmp_lk(lk_q.pop_front());
      end else if (lk_ready !== 1'b0) miss("stray lookup answer");
      if (dn_d) begin
        if (irq_q.size() == 0) miss("completion without note");
        else cmp_irq(irq_q.pop_front());
      end else if (txn_irq !== 1'b0) miss("stray completion event");
      {rd_d, lk_d, dn_d} = {bus_rd, lk_valid, done_valid};
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    {srst, bus_wr, bus_rd, bus_addr, bus_wdata} = {3'b100, 7'h00, 8'h00};
    sh = '{default: 8'h00};
    void'($urandom(44));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 128; i++) rd(i[6], i[5:3], i[2:0]);
    for (int i = 0; i < 128; i++) wr(i[6], i[5:3], i[2:0], rnd(i[2:0]));
    for (int i = 0; i < 128; i++) rd(i[6], i[5:3], i[2:0]);
    for (int i = 0; i < 16; i++) lk(i[3], i[2:0]);
    // Double-buffered output endpoint alternates X and Y
    wr(0, 3, `UEB_OFF_CFG, 8'h94);
    repeat (3) begin
      lk(0, 3);
      cp(0, 3, 7'($urandom_range(0, 64)));
    end
    lk(0, 3);
    rd(0, 3, `UEB_OFF_XBASE);
    rd(0, 3, `UEB_OFF_YBASE);
    wr(1, 2, `UEB_OFF_CFG, 8'h14);
    cp(1, 2, 7'h10);
    lk(1, 2);
    // Stall raised by the manager, cleared by software
    wr(1, 6, `UEB_OFF_CFG, 8'h80);
    st(6);
    lk(1, 6);
    rd(1, 6, `UEB_OFF_CFG);
    wr(1, 6, `UEB_OFF_CFG, 8'h80);
    lk(1, 6);
    // Random traffic over all endpoints including refused ones
    repeat (400) begin
      automatic logic d = 1'($urandom);
      automatic logic [2:0] e = 3'($urandom);
      automatic logic [2:0] o = 3'($urandom);
      case ($urandom_range(0, 4))
        0: wr(d, e, o, rnd(o));
        1: rd(d, e, o);
        2: lk(d, e);
        3: cp(d, e, 7'($urandom_range(0, 64)));
        default: st(e);
      endcase
    end
    repeat (4) @(posedge clk);
    if (rd_q.size() + lk_q.size() + irq_q.size() != 0) miss("results missing");
    test_done();
  end
endmodule // tb
`default_nettype wire

//--- bench/ueb_host_model.sv
// Host and buffer-manager model: token lookups, transaction completions, stall requests
`timescale 1ns/1ps
`default_nettype none
module ueb_host_model (
  input  wire logic       clk,
  output logic            lk_valid,
  output logic            lk_dir_in,
  output logic [2:0]      lk_ep,
  output logic            done_valid,
  output logic            done_dir_in,
  output logic [2:0]      done_ep,
  output logic [6:0]      done_count,
  output logic            stall_set,
  output logic [2:0]      stall_ep
);
  // Idle at time zero; qualifiers never look meaningful outside a request
  initial begin
    {lk_valid, lk_dir_in, lk_ep} = 5'h0A;
    {done_valid, done_dir_in, done_ep, done_count} = 12'h5A5;
    {stall_set, stall_ep} = 4'h5;
  end

  // One-cycle token lookup, qualifiers scrambled on release
  task automatic lookup(input logic d, input logic [2:0] e);
    @(posedge clk);
    {lk_valid, lk_dir_in, lk_ep} <= {1'b1, d, e};
    @(posedge clk);
    {lk_valid, lk_dir_in, lk_ep} <= {1'b0, ~d, ~e};
  endtask

  task automatic complete(input logic d, input logic [2:0] e, input logic [6:0] n);
    @(posedge clk);
    {done_valid, done_dir_in, done_ep} <= {1'b1, d, e};
    done_count <= (n > 7'h40) ? 7'h40 : n;
    @(posedge clk);
    {done_valid, done_dir_in, done_ep, done_count} <= {1'b0, ~d, ~e, ~n};
  endtask

  // Buffer manager flags a stall on an input endpoint
  task automatic stall(input logic [2:0] e);
    @(posedge clk);
    {stall_set, stall_ep} <= {1'b1, e};
    @(posedge clk);
    {stall_set, stall_ep} <= {1'b0, ~e};
  endtask
endmodule // ueb_host_model
`default_nettype wire

//--- rtl/ueb_buf_select.sv
// Selects the X or Y buffer of one descriptor and forms its start address
`timescale 1ns/1ps
`default_nettype none
`include "ueb_params.svh"
module ueb_buf_select
  import ueb_pkg::*;
(
  input  wire logic [7:0]  cfg,
  input  wire logic [7:0]  x_base,
  input  wire logic [7:0]  x_cnt,
  input  wire logic [7:0]  y_base,
  input  wire logic [7:0]  y_cnt,
  output logic             use_y,
  output logic [10:0]      start_addr,
  output logic [7:0]       cnt_byte,
  output logic [2:0]       cnt_off
);
  // Toggle picks the buffer only when double buffering is on
  always_comb begin
    use_y      = cfg[`UEB_CFG_DBL_BUF] & cfg[`UEB_CFG_TOGGLE];
    start_addr = use_y ? {y_base, `UEB_BASE_PAD} : {x_base, `UEB_BASE_PAD};
    cnt_byte   = use_y ? y_cnt : x_cnt;
    cnt_off    = use_y ? `UEB_OFF_YCNT : `UEB_OFF_XCNT;
  end
endmodule // ueb_buf_select
`default_nettype wire

//--- rtl/ueb_complete.sv
// Computes the count entry and toggle after a completed transaction
`timescale 1ns/1ps
`default_nettype none
`include "ueb_params.svh"
module ueb_complete
  import ueb_pkg::*;
(
  input  wire logic                dir_in,
  input  wire logic [7:0]          cnt_old,
  input  wire logic [`UEB_CNT_W-1:0] rx_count,
  input  wire logic                tog_old,
  output logic [7:0]               cnt_new,
  output logic                     tog_new
);
  // Both directions end with NAK set: OUT buffer full, IN buffer drained
  always_comb begin
    cnt_new = dir_in ? {1'b1, cnt_old[`UEB_CNT_W-1:0]} : {1'b1, rx_count};
    tog_new = ~tog_old;
  end
endmodule // ueb_complete
`default_nettype wire

//--- rtl/ueb_desc_bank.sv
// Endpoint descriptor bank for data endpoints 1 to 7, both directions
//
// Behaviour
// - Base entry holds address bits 10..3; start address appends three zeros.
// - Buffer accesses start at the selected buffer's programmed base address.
// - Completion never alters any base-address entry.
// - Count field bits 6..0 give packet length, zero to sixty-four bytes.
// - Output endpoint: NAK bit set means buffer full, host OUT gets NAK.
// - Input endpoint: NAK bit set means buffer empty, host IN gets NAK.
// - Interrupt-enable bit raises a completion event per finished transaction.
// - Stall bit resets clear; while set host gets STALL; software clears it.
// - On input endpoints the buffer manager may also set stall.
// - Double-buffer bit off uses X only; on, toggle picks X or Y.
// - Toggle bit tracks the endpoint's DATA0/DATA1 sequence.
// - Allow bit gates all buffer-manager use of the endpoint; the manager stall set on input endpoints does not check it.
// - Independent descriptors exist for endpoints one to seven, each direction.
// - Entries sit at offsets 00,01,02,05,06,07; 03 and 04 unused.
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ueb_params.svh"
module ueb_desc_bank
  import ueb_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic [`UEB_ADDR_W-1:0] bus_addr,
  input  wire logic [7:0]             bus_wdata,
  input  wire logic                   bus_wr,
  input  wire logic                   bus_rd,
  output logic [7:0]                  bus_rdata,
  input  wire logic                   lk_valid,
  input  wire logic                   lk_dir_in,
  input  wire logic [2:0]             lk_ep,
  output logic                        lk_ready,
  output logic                        lk_allow,
  output logic [10:0]                 lk_start_addr,
  output logic [6:0]                  lk_size,
  output logic [6:0]                  lk_count,
  output logic                        lk_toggle,
  output logic                        lk_use_y,
  output ueb_resp_t                   lk_resp,
  input  wire logic                   done_valid,
  input  wire logic                   done_dir_in,
  input  wire logic [2:0]             done_ep,
  input  wire logic [6:0]             done_count,
  input  wire logic                   stall_set,
  input  wire logic [2:0]             stall_ep,
  output logic                        txn_irq
);
  localparam int NUM_ROWS = 16;

  logic [7:0]      mem_reg  [NUM_ROWS][8];
  logic [7:0]      mem_next [NUM_ROWS][8];
  logic [7:0]      rdata_reg, rdata_next;
  logic            irq_reg, irq_next;
  logic            lk_ready_reg, lk_ready_next;
  logic            lk_allow_reg, lk_allow_next;
  logic [10:0]     lk_addr_reg, lk_addr_next;
  logic [6:0]      lk_size_reg, lk_size_next;
  logic [6:0]      lk_count_reg, lk_count_next;
  logic            lk_tog_reg, lk_tog_next;
  logic            lk_use_y_reg, lk_use_y_next;
  ueb_resp_t       lk_resp_reg, lk_resp_next;
  logic [3:0]      lk_idx, dn_idx;
  logic            lk_sel_y, dn_sel_y;
  logic [10:0]     lk_sel_addr;
  logic [7:0]      lk_sel_cnt, dn_sel_cnt, dn_cnt_new;
  logic [2:0]      dn_cnt_off;
  logic            dn_ok, dn_tog_new;

  // offset map: endpoint 0 rows and the two spare offsets stay outside the bank
  function automatic logic addr_ok(input logic [`UEB_ADDR_W-1:0] a);
    addr_ok = (a[5:3] != 3'h0) && (a[2:0] != `UEB_OFF_SPARE0) && (a[2:0] != `UEB_OFF_SPARE1);
  endfunction

  // Writable mask per entry; reserved bits never store a one
  function automatic logic [7:0] wr_mask(input logic [2:0] off);
    case (off)
      `UEB_OFF_CFG:  wr_mask = `UEB_CFG_WMASK;
      `UEB_OFF_SIZE: wr_mask = `UEB_SIZE_WMASK;
      default:       wr_mask = `UEB_FULL_WMASK;
    endcase
  endfunction

  assign lk_idx = {lk_dir_in, lk_ep};
  assign dn_idx = {done_dir_in, done_ep};

  // Lookup buffer choice
  ueb_buf_select u_lk_sel (
    .cfg        (mem_reg[lk_idx][`UEB_OFF_CFG]),
    .x_base     (mem_reg[lk_idx][`UEB_OFF_XBASE]),
    .x_cnt      (mem_reg[lk_idx][`UEB_OFF_XCNT]),
    .y_base     (mem_reg[lk_idx][`UEB_OFF_YBASE]),
    .y_cnt      (mem_reg[lk_idx][`UEB_OFF_YCNT]),
    .use_y      (lk_sel_y),
    .start_addr (lk_sel_addr),
    .cnt_byte   (lk_sel_cnt),
    .cnt_off    ()
  );

  // Completion buffer choice
  ueb_buf_select u_dn_sel (
    .cfg        (mem_reg[dn_idx][`UEB_OFF_CFG]),
    .x_base     (mem_reg[dn_idx][`UEB_OFF_XBASE]),
    .x_cnt      (mem_reg[dn_idx][`UEB_OFF_XCNT]),
    .y_base     (mem_reg[dn_idx][`UEB_OFF_YBASE]),
    .y_cnt      (mem_reg[dn_idx][`UEB_OFF_YCNT]),
    .use_y      (dn_sel_y),
    .start_addr (),
    .cnt_byte   (dn_sel_cnt),
    .cnt_off    (dn_cnt_off)
  );

  ueb_complete u_complete (
    .dir_in   (done_dir_in),
    .cnt_old  (dn_sel_cnt),
    .rx_count (done_count),
    .tog_old  (mem_reg[dn_idx][`UEB_OFF_CFG][`UEB_CFG_TOGGLE]),
    .cnt_new  (dn_cnt_new),
    .tog_new  (dn_tog_new)
  );

  // allow gate: disabled endpoints see no completion update
  assign dn_ok = done_valid && (done_ep != 3'h0)
               && mem_reg[dn_idx][`UEB_OFF_CFG][`UEB_CFG_ALLOW];

  // Descriptor storage next state; hardware updates follow the software write so set wins
  always_comb begin
    mem_next = mem_reg;
    // per-endpoint rows: address picks direction, endpoint and offset
    if (bus_wr && addr_ok(bus_addr)) begin
      mem_next[bus_addr[6:3]][bus_addr[2:0]] = bus_wdata & wr_mask(bus_addr[2:0]);
    end
    // alternate buffers: flipping toggle moves a double-buffered endpoint to the other buffer
    if (dn_ok) begin
      mem_next[dn_idx][`UEB_OFF_CFG][`UEB_CFG_TOGGLE] = dn_tog_new;
      // NAK update; base entries are never touched here
      mem_next[dn_idx][dn_cnt_off] = dn_cnt_new;
    end
    // manager stall set, input endpoints only
    if (stall_set && (stall_ep != 3'h0)) begin
      mem_next[{1'b1, stall_ep}][`UEB_OFF_CFG][`UEB_CFG_STALL] = 1'b1;
    end
  end

  // stall cleared at reset, along with every other entry
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int r = 0; r < NUM_ROWS; r++) begin
        for (int o = 0; o < 8; o++) begin
          mem_reg[r][o] <= `UEB_ENTRY_RST;
        end
      end
    end else begin
      mem_reg <= mem_next;
    end
  end

  // Read data only in the cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_next = 8'h00;
    if (bus_rd && addr_ok(bus_addr)) begin
      rdata_next = mem_reg[bus_addr[6:3]][bus_addr[2:0]];
    end
    irq_next = dn_ok && mem_reg[dn_idx][`UEB_OFF_CFG][`UEB_CFG_IRQ_EN];
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg <= 8'h00;
      irq_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      irq_reg   <= irq_next;
    end
  end

  // Lookup answer for the buffer manager and host handshake
  always_comb begin
    lk_ready_next  = lk_valid;
    lk_allow_next  = 1'b0;
    lk_addr_next   = lk_addr_reg;
    lk_size_next   = lk_size_reg;
    lk_count_next  = lk_count_reg;
    lk_tog_next    = lk_tog_reg;
    lk_use_y_next  = lk_use_y_reg;
    lk_resp_next   = lk_resp_reg;
    if (lk_valid) begin
      lk_allow_next = (lk_ep != 3'h0) && mem_reg[lk_idx][`UEB_OFF_CFG][`UEB_CFG_ALLOW];
      lk_addr_next  = lk_sel_addr;
      lk_size_next  = mem_reg[lk_idx][`UEB_OFF_SIZE][6:0];
      lk_count_next = lk_sel_cnt[6:0];
      lk_tog_next   = mem_reg[lk_idx][`UEB_OFF_CFG][`UEB_CFG_TOGGLE];
      lk_use_y_next = lk_sel_y;
      // stall first; disabled endpoint is NAKed; NAK bit
      if ((lk_ep != 3'h0) && mem_reg[lk_idx][`UEB_OFF_CFG][`UEB_CFG_STALL]) begin
        lk_resp_next = UEB_RESP_STALL;
      end else if (!lk_allow_next || lk_sel_cnt[`UEB_CNT_NAK]) begin
        lk_resp_next = UEB_RESP_NAK;
      end else begin
        lk_resp_next = UEB_RESP_ACK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lk_ready_reg <= 1'b0;
      lk_allow_reg <= 1'b0;
      lk_addr_reg  <= 11'h000;
      lk_size_reg  <= 7'h00;
      lk_count_reg <= 7'h00;
      lk_tog_reg   <= 1'b0;
      lk_use_y_reg <= 1'b0;
      lk_resp_reg  <= UEB_RESP_NAK;
    end else begin
      lk_ready_reg <= lk_ready_next;
      lk_allow_reg <= lk_allow_next;
      lk_addr_reg  <= lk_addr_next;
      lk_size_reg  <= lk_size_next;
      lk_count_reg <= lk_count_next;
      lk_tog_reg   <= lk_tog_next;
      lk_use_y_reg <= lk_use_y_next;
      lk_resp_reg  <= lk_resp_next;
    end
  end

  assign bus_rdata     = rdata_reg;
  assign txn_irq       = irq_reg;
  assign lk_ready      = lk_ready_reg;
  assign lk_allow      = lk_allow_reg;
  assign lk_start_addr = lk_addr_reg;
  assign lk_size       = lk_size_reg;
  assign lk_count      = lk_count_reg;
  assign lk_toggle     = lk_tog_reg;
  assign lk_use_y      = lk_use_y_reg;
  assign lk_resp       = lk_resp_reg;

  // Checking helpers: remember what a completion touched
  logic [3:0] chk_idx_q;
  logic [2:0] chk_off_q;
  logic       chk_ok_q, chk_tog_q, chk_wr_q;
  logic [7:0] chk_xb_q, chk_yb_q, chk_lb_q;
  always_ff @(posedge clk) begin
    chk_idx_q <= dn_idx;
    chk_off_q <= dn_cnt_off;
    chk_ok_q  <= dn_ok && !srst;
    chk_tog_q <= mem_reg[dn_idx][`UEB_OFF_CFG][`UEB_CFG_TOGGLE];
    chk_wr_q  <= bus_wr;
    chk_xb_q  <= mem_reg[dn_idx][`UEB_OFF_XBASE];
    chk_yb_q  <= mem_reg[dn_idx][`UEB_OFF_YBASE];
    // Base a lookup should use, worked out from the config bits, not the selector
    chk_lb_q  <= (mem_reg[lk_idx][`UEB_OFF_CFG][`UEB_CFG_DBL_BUF]
                  && mem_reg[lk_idx][`UEB_OFF_CFG][`UEB_CFG_TOGGLE])
                 ? mem_reg[lk_idx][`UEB_OFF_YBASE] : mem_reg[lk_idx][`UEB_OFF_XBASE];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  cfg_reserved_a: assert property (bus_rd && bus_addr[2:0] == `UEB_OFF_CFG |=> bus_rdata[1:0] == 2'h0)
    else $error("config reserved bits read non-zero");
  size_reserved_a: assert property (bus_rd && bus_addr[2:0] == `UEB_OFF_SIZE |=> !bus_rdata[7])
    else $error("size reserved bit read non-zero");
  start_addr_a: assert property (lk_valid |=> lk_start_addr == {chk_lb_q, 3'h0})
    else $error("start address not the selected base");
  stall_resp_a: assert property (lk_valid && lk_ep != 3'h0
      && mem_reg[lk_idx][`UEB_OFF_CFG][`UEB_CFG_STALL] |=> lk_resp == UEB_RESP_STALL)
    else $error("stalled endpoint not answered with stall");
  irq_event_a: assert property (done_valid |=> txn_irq == $past(done_ep != 3'h0
      && mem_reg[dn_idx][`UEB_OFF_CFG][`UEB_CFG_ALLOW]
      && mem_reg[dn_idx][`UEB_OFF_CFG][`UEB_CFG_IRQ_EN]))
    else $error("completion event does not follow enable");
  irq_gate_a: assert property (!dn_ok |=> !txn_irq)
    else $error("event raised for a disabled endpoint");
  toggle_flip_a: assert property (chk_ok_q && !chk_wr_q
      |-> mem_reg[chk_idx_q][`UEB_OFF_CFG][`UEB_CFG_TOGGLE] != chk_tog_q)
    else $error("toggle did not flip on completion");
  nak_set_a: assert property (chk_ok_q |-> mem_reg[chk_idx_q][chk_off_q][`UEB_CNT_NAK])
    else $error("NAK not set after completion");
  base_kept_a: assert property (chk_ok_q && !chk_wr_q
      |-> mem_reg[chk_idx_q][`UEB_OFF_XBASE] == chk_xb_q
       && mem_reg[chk_idx_q][`UEB_OFF_YBASE] == chk_yb_q)
    else $error("base entry changed by completion");
  stall_set_a: assert property (stall_set && stall_ep != 3'h0
      |=> mem_reg[{1'b1, $past(stall_ep)}][`UEB_OFF_CFG][`UEB_CFG_STALL])
    else $error("manager stall set lost");

  double_buffer_enable_done_c:  cover property (dn_ok && dn_sel_y);
  stall_resp_c: cover property (lk_ready && lk_resp == UEB_RESP_STALL);
  irq_c:        cover property (txn_irq);
  ack_c:        cover property (lk_ready && lk_resp == UEB_RESP_ACK && lk_use_y);
endmodule // ueb_desc_bank
`default_nettype wire

//--- rtl/ueb_params.svh
// Offsets, field positions, reset values and address layout of the endpoint descriptor bank
`ifndef UEB_PARAMS_SVH
`define UEB_PARAMS_SVH

// Entry offsets inside one eight-byte descriptor
`define UEB_OFF_CFG    3'h0
`define UEB_OFF_XBASE  3'h1
`define UEB_OFF_XCNT   3'h2
`define UEB_OFF_SPARE0 3'h3
`define UEB_OFF_SPARE1 3'h4
`define UEB_OFF_YBASE  3'h5
`define UEB_OFF_YCNT   3'h6
`define UEB_OFF_SIZE   3'h7

// Configuration entry bit positions
`define UEB_CFG_IRQ_EN  2
`define UEB_CFG_STALL   3
`define UEB_CFG_DBL_BUF 4
`define UEB_CFG_TOGGLE  5
`define UEB_CFG_ISO     6
`define UEB_CFG_ALLOW   7

// Count entry: NAK flag and count field
`define UEB_CNT_NAK     7
`define UEB_CNT_W       7

// Writable-bit masks; reserved bits are forced to zero
`define UEB_CFG_WMASK   8'hFC
`define UEB_SIZE_WMASK  8'h7F
`define UEB_FULL_WMASK  8'hFF

// Register-port address: {direction, endpoint[2:0], offset[2:0]}; direction 1 = input
`define UEB_ADDR_W      7
`define UEB_DIR_BIT     6
`define UEB_BASE_PAD    3'h0
`define UEB_ENTRY_RST   8'h00

`endif

//--- rtl/ueb_pkg.sv
// Types shared by the endpoint descriptor bank
package ueb_pkg;
  // Handshake the endpoint gives the host for the looked-up buffer
  typedef enum logic [1:0] {
    UEB_RESP_ACK,
    UEB_RESP_NAK,
    UEB_RESP_STALL
  } ueb_resp_t;
endpackage
